// file: include/ivm_pkg.sv
// Package for the peripheral interrupt vector map.
// Assumes one system clock domain shared by all sources and the CPU.
package ivm_pkg;

  // ---------------------------------------------------------------
  // Vector numbers
  // ---------------------------------------------------------------
  localparam int unsigned NUM_VECTORS  = 36;
  localparam int unsigned VEC_W        = 6;
  localparam int unsigned ADDR_W       = 7;
  localparam int unsigned WORDS_PER_VEC = 2;

  localparam logic [VEC_W-1:0] VEC_RESET       = 6'h00;
  localparam logic [VEC_W-1:0] VEC_NMI         = 6'h01;
  localparam logic [VEC_W-1:0] VEC_VLM         = 6'h02;
  localparam logic [VEC_W-1:0] VEC_CLK_FAIL    = 6'h03;
  localparam logic [VEC_W-1:0] VEC_MULTIVOLT   = 6'h04;
  localparam logic [VEC_W-1:0] VEC_RTC_COUNT   = 6'h05;
  localparam logic [VEC_W-1:0] VEC_RTC_PERIOD  = 6'h06;
  localparam logic [VEC_W-1:0] VEC_CUSTOM      = 6'h07;
  localparam logic [VEC_W-1:0] VEC_PORT_A      = 6'h08;
  localparam logic [VEC_W-1:0] VEC_TA_OVF      = 6'h09;
  localparam logic [VEC_W-1:0] VEC_TA_HUNF     = 6'h0a;
  localparam logic [VEC_W-1:0] VEC_TA_CMP0     = 6'h0b;
  localparam logic [VEC_W-1:0] VEC_TA_CMP1     = 6'h0c;
  localparam logic [VEC_W-1:0] VEC_TA_CMP2     = 6'h0d;
  localparam logic [VEC_W-1:0] VEC_TB0         = 6'h0e;
  localparam logic [VEC_W-1:0] VEC_TB1         = 6'h0f;
  localparam logic [VEC_W-1:0] VEC_TD_OVF      = 6'h10;
  localparam logic [VEC_W-1:0] VEC_TD_TRIG     = 6'h11;
  localparam logic [VEC_W-1:0] VEC_TW_CLIENT   = 6'h12;
  localparam logic [VEC_W-1:0] VEC_TW_HOST     = 6'h13;
  localparam logic [VEC_W-1:0] VEC_SPI         = 6'h14;
  localparam logic [VEC_W-1:0] VEC_UART0_BASE  = 6'h15;
  localparam logic [VEC_W-1:0] VEC_PORT_D      = 6'h18;
  localparam logic [VEC_W-1:0] VEC_COMPARATOR  = 6'h19;
  localparam logic [VEC_W-1:0] VEC_ADC_RESULT  = 6'h1a;
  localparam logic [VEC_W-1:0] VEC_ADC_WINDOW  = 6'h1b;
  localparam logic [VEC_W-1:0] VEC_ZERO_CROSS  = 6'h1c;
  localparam logic [VEC_W-1:0] VEC_PORT_C      = 6'h1d;
  localparam logic [VEC_W-1:0] VEC_TB2         = 6'h1e;
  localparam logic [VEC_W-1:0] VEC_UART1_BASE  = 6'h1f;
  localparam logic [VEC_W-1:0] VEC_PORT_F      = 6'h22;
  localparam logic [VEC_W-1:0] VEC_EEPROM      = 6'h23;

  // Reset values of outputs
  localparam logic [VEC_W-1:0]  VEC_RST_VAL  = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST_VAL = 7'h00;

  // ---------------------------------------------------------------
  // Source bundles
  // ---------------------------------------------------------------
  // One flag and enable pair per physical source
  typedef struct packed {
    logic flag;
    logic enable;
  } ivm_src_t;

  typedef struct packed {
    logic rx_done;
    logic tx_empty;
    logic tx_done;
  } ivm_uart_t;

  typedef struct packed {
    ivm_src_t clock_fail_detect;
    ivm_src_t multivolt_io_irq;
    ivm_src_t rtc_overflow;
    ivm_src_t rtc_compare;
    ivm_src_t rtc_periodic_irq;
    ivm_src_t custom_logic_irq;
    ivm_src_t port_a_pin_irq;
    ivm_src_t port_c_pin_irq;
    ivm_src_t port_d_pin_irq;
    ivm_src_t port_f_pin_irq;
    ivm_src_t timer_a_overflow_irq;
    ivm_src_t timer_a_low_underflow_irq;
    ivm_src_t timer_a_high_underflow_irq;
    ivm_src_t [2:0] timer_a_compare_irq;
    ivm_src_t [2:0] timer_a_low_compare_irq;
    ivm_src_t [2:0] timer_b_capture;
    ivm_src_t [2:0] timer_b_overflow;
    ivm_src_t timer_d_overflow_irq;
    ivm_src_t timer_d_trigger_irq;
    ivm_src_t twowire_client_irq;
    ivm_src_t twowire_host_irq;
    ivm_src_t serial_periph_irq;
    ivm_uart_t [1:0] uart_flag;
    ivm_uart_t [1:0] uart_enable;
    ivm_src_t comparator_irq;
    ivm_src_t adc_result_ready_irq;
    ivm_src_t adc_window_irq;
    ivm_src_t zero_cross_irq;
    ivm_src_t eeprom_ready_irq;
  } ivm_sources_t;

  typedef struct packed {
    logic [NUM_VECTORS-1:0] pending;
    logic                   any;
    logic [VEC_W-1:0]       vector;
    logic [ADDR_W-1:0]      address;
  } ivm_fetch_t;

endpackage

// file: logic/ivm_vector_map.sv
// Peripheral interrupt vector map: source requests to vector lines and fetch address.
// Assumes sources and CPU share ref_clk_i; flags are cleared by software in the peripherals.
//
// Notes on behaviour
// - Vectors 0, 1, 2 are reset, NMI and level monitor at 0x00, 0x02, 0x04.
// - Peripheral request only while enable, flag and global enable are set; holds until flag clears.
// - Clock failure detection goes to vector 3, address 0x06.
// - Multi-voltage I/O monitor goes to vector 4, address 0x08.
// - Counter overflow and compare share vector 5, address 0x0A.
// - Periodic counter interrupt goes alone to vector 6, address 0x0C.
// - Custom logic interrupt goes to vector 7, address 0x0E.
// - Vector 9 is timer A overflow, or low underflow in split mode.
// - Vector 10 unused in normal mode, high underflow in split mode.
// - Vectors 11 to 13 carry compares 0 to 2, low compares when split.
// - Timer B instances 0, 1, 2 use vectors 14, 15, 30 combined.
// - Timer D overflow on vector 16, trigger on vector 17.
// - Two-wire client on vector 18, host on vector 19.
// - Serial peripheral interface uses single vector 20.
// - UART receive, data empty, transmit done: vectors 21-23 and 31-33.
// - Comparator 25, ADC result 26, ADC window 27, zero cross 28.
// - Port pins: A vector 8, D 24, C 29, F 34.
// - EEPROM ready is vector 35 at 0x46, highest in table.
module ivm_vector_map (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       clk_en_i,
  // Global control
  input  wire logic                       global_irq_en_i,
  input  wire logic                       timer_a_split_i,
  // System level sources
  input  wire logic                       nmi_req_i,
  input  wire logic                       vlm_req_i,
  // Peripheral sources
  input  wire ivm_pkg::ivm_sources_t      src_i,
  // CPU side
  output logic [ivm_pkg::NUM_VECTORS-1:0] vec_req_o,
  output logic                            vec_any_o,
  output logic [ivm_pkg::VEC_W-1:0]       vec_num_o,
  output logic [ivm_pkg::ADDR_W-1:0]      vec_addr_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic src_req(input ivm_pkg::ivm_src_t s);
    src_req = s.flag & s.enable;
  endfunction

  function automatic logic [ivm_pkg::ADDR_W-1:0] vec_to_addr(input logic [ivm_pkg::VEC_W-1:0] v);
    vec_to_addr = {v, 1'b0};
  endfunction

  // ---------------------------------------------------------------
  // Source to vector routing
  // ---------------------------------------------------------------
  logic [ivm_pkg::NUM_VECTORS-1:0] raw_req;
  logic [ivm_pkg::NUM_VECTORS-1:0] gated_req;

  always_comb
  begin
    raw_req = '0;
    // Reset vector is never requested as an interrupt
    raw_req[ivm_pkg::VEC_RESET]      = 1'b0;
    raw_req[ivm_pkg::VEC_NMI]        = nmi_req_i;
    raw_req[ivm_pkg::VEC_VLM]        = vlm_req_i;
    raw_req[ivm_pkg::VEC_CLK_FAIL]   = src_req(src_i.clock_fail_detect);
    raw_req[ivm_pkg::VEC_MULTIVOLT]  = src_req(src_i.multivolt_io_irq);
    raw_req[ivm_pkg::VEC_RTC_COUNT]  = src_req(src_i.rtc_overflow) | src_req(src_i.rtc_compare);
    raw_req[ivm_pkg::VEC_RTC_PERIOD] = src_req(src_i.rtc_periodic_irq);
    raw_req[ivm_pkg::VEC_CUSTOM]     = src_req(src_i.custom_logic_irq);
    raw_req[ivm_pkg::VEC_PORT_A]     = src_req(src_i.port_a_pin_irq);
    raw_req[ivm_pkg::VEC_PORT_D]     = src_req(src_i.port_d_pin_irq);
    raw_req[ivm_pkg::VEC_PORT_C]     = src_req(src_i.port_c_pin_irq);
    raw_req[ivm_pkg::VEC_PORT_F]     = src_req(src_i.port_f_pin_irq);
    // Mode picks which timer A source owns the shared vectors
    if (timer_a_split_i)
    begin
      raw_req[ivm_pkg::VEC_TA_OVF]  = src_req(src_i.timer_a_low_underflow_irq);
      raw_req[ivm_pkg::VEC_TA_HUNF] = src_req(src_i.timer_a_high_underflow_irq);
      raw_req[ivm_pkg::VEC_TA_CMP0] = src_req(src_i.timer_a_low_compare_irq[0]);
      raw_req[ivm_pkg::VEC_TA_CMP1] = src_req(src_i.timer_a_low_compare_irq[1]);
      raw_req[ivm_pkg::VEC_TA_CMP2] = src_req(src_i.timer_a_low_compare_irq[2]);
    end
    else
    begin
      raw_req[ivm_pkg::VEC_TA_OVF]  = src_req(src_i.timer_a_overflow_irq);
      raw_req[ivm_pkg::VEC_TA_HUNF] = 1'b0;
      raw_req[ivm_pkg::VEC_TA_CMP0] = src_req(src_i.timer_a_compare_irq[0]);
      raw_req[ivm_pkg::VEC_TA_CMP1] = src_req(src_i.timer_a_compare_irq[1]);
      raw_req[ivm_pkg::VEC_TA_CMP2] = src_req(src_i.timer_a_compare_irq[2]);
    end
    raw_req[ivm_pkg::VEC_TB0] = src_req(src_i.timer_b_capture[0]) | src_req(src_i.timer_b_overflow[0]);
    raw_req[ivm_pkg::VEC_TB1] = src_req(src_i.timer_b_capture[1]) | src_req(src_i.timer_b_overflow[1]);
    raw_req[ivm_pkg::VEC_TB2] = src_req(src_i.timer_b_capture[2]) | src_req(src_i.timer_b_overflow[2]);
    raw_req[ivm_pkg::VEC_TD_OVF]     = src_req(src_i.timer_d_overflow_irq);
    raw_req[ivm_pkg::VEC_TD_TRIG]    = src_req(src_i.timer_d_trigger_irq);
    raw_req[ivm_pkg::VEC_TW_CLIENT]  = src_req(src_i.twowire_client_irq);
    raw_req[ivm_pkg::VEC_TW_HOST]    = src_req(src_i.twowire_host_irq);
    raw_req[ivm_pkg::VEC_SPI]        = src_req(src_i.serial_periph_irq);
    raw_req[ivm_pkg::VEC_COMPARATOR] = src_req(src_i.comparator_irq);
    raw_req[ivm_pkg::VEC_ADC_RESULT] = src_req(src_i.adc_result_ready_irq);
    raw_req[ivm_pkg::VEC_ADC_WINDOW] = src_req(src_i.adc_window_irq);
    raw_req[ivm_pkg::VEC_ZERO_CROSS] = src_req(src_i.zero_cross_irq);
    raw_req[ivm_pkg::VEC_EEPROM]     = src_req(src_i.eeprom_ready_irq);
  end

  // ---------------------------------------------------------------
  // UART vector triples
  // ---------------------------------------------------------------
  logic [2:0] uart_req [2];

  genvar gu;
  generate
    for (gu = 0; gu < 2; gu++)
    begin : g_uart
      assign uart_req[gu] = src_i.uart_flag[gu] & src_i.uart_enable[gu];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Global gating
  // ---------------------------------------------------------------
  always_comb
  begin
    gated_req = raw_req;
    // Receive, data empty, transmit done in ascending vector order
    gated_req[ivm_pkg::VEC_UART0_BASE]      = uart_req[0][2];
    gated_req[ivm_pkg::VEC_UART0_BASE + 1]  = uart_req[0][1];
    gated_req[ivm_pkg::VEC_UART0_BASE + 2]  = uart_req[0][0];
    gated_req[ivm_pkg::VEC_UART1_BASE]      = uart_req[1][2];
    gated_req[ivm_pkg::VEC_UART1_BASE + 1]  = uart_req[1][1];
    gated_req[ivm_pkg::VEC_UART1_BASE + 2]  = uart_req[1][0];
    // NMI ignores the global enable; maskable vectors do not
    if (!global_irq_en_i)
    begin
      gated_req = '0;
      gated_req[ivm_pkg::VEC_NMI] = nmi_req_i;
    end
  end

  // ---------------------------------------------------------------
  // Selection: lowest vector number wins
  // ---------------------------------------------------------------
  ivm_pkg::ivm_fetch_t fetch_reg;
  ivm_pkg::ivm_fetch_t fetch_next;

  always_comb
  begin
    fetch_next         = fetch_reg;
    fetch_next.pending = gated_req;
    fetch_next.any     = |gated_req;
    fetch_next.vector  = ivm_pkg::VEC_RST_VAL;
    for (int i = int'(ivm_pkg::NUM_VECTORS) - 1; i >= 0; i--)
    begin
      if (gated_req[i])
      begin
        fetch_next.vector = ivm_pkg::VEC_W'(i);
      end
    end
    fetch_next.address = vec_to_addr(fetch_next.vector);
  end

  // Clock enable freezes the whole view seen by the CPU
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fetch_reg.pending <= '0;
      fetch_reg.any     <= 1'b0;
      fetch_reg.vector  <= ivm_pkg::VEC_RST_VAL;
      fetch_reg.address <= ivm_pkg::ADDR_RST_VAL;
    end
    else if (clk_en_i)
    begin
      fetch_reg <= fetch_next;
    end
  end

  assign vec_req_o  = fetch_reg.pending;
  assign vec_any_o  = fetch_reg.any;
  assign vec_num_o  = fetch_reg.vector;
  assign vec_addr_o = fetch_reg.address;

endmodule

// file: dv/ivm_cpu_model.sv
// CPU core model: takes the vector fetch address whenever a request is seen.
// Assumes the map's outputs are registered on ref_clk_i.
module ivm_cpu_model (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       arst_n_i,
  // Vector side
  input  wire logic                       vec_any_i,
  input  wire logic [ivm_pkg::ADDR_W-1:0] vec_addr_i,
  // Observed fetch
  output logic      [ivm_pkg::ADDR_W-1:0] fetch_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // No handshake back to the map: the core only reads vec_any_i and the address
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      fetch_addr_o <= 7'h00;
    else if (vec_any_i)
      fetch_addr_o <= vec_addr_i;
endmodule

// file: dv/ivm_vector_map_checker.sv
// Checker for the vector map, bound to its ports.
// Assumes one clock domain and asynchronous active-low reset.
module ivm_vector_map_checker (
  // Clock and reset
  input wire logic                            ref_clk_i,
  input wire logic                            arst_n_i,
  input wire logic                            clk_en_i,
  // Controls and sources
  input wire logic                            global_irq_en_i,
  input wire logic                            timer_a_split_i,
  input wire logic                            nmi_req_i,
  input wire ivm_pkg::ivm_sources_t           src_i,
  // CPU side
  input wire logic [ivm_pkg::NUM_VECTORS-1:0] vec_req_o,
  input wire logic [ivm_pkg::VEC_W-1:0]       vec_num_o,
  input wire logic [ivm_pkg::ADDR_W-1:0]      vec_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Sampled reset in each |=> antecedent: on the release edge the map is still held in reset
  sequence s_spi_on;
    arst_n_i && clk_en_i && global_irq_en_i && src_i.serial_periph_irq.flag && src_i.serial_periph_irq.enable;
  endsequence
  sequence s_spi_off;
    clk_en_i && !src_i.serial_periph_irq.flag;
  endsequence
  property p_addr_twice; vec_addr_o == {vec_num_o, 1'b0}; endproperty
  property p_no_reset_vec; !vec_req_o[0]; endproperty
  property p_nmi; arst_n_i && clk_en_i && nmi_req_i |=> vec_req_o[1]; endproperty
  property p_lowest;
    vec_req_o != 36'h0 |-> vec_req_o[vec_num_o] && ((vec_req_o & ((36'h1 << vec_num_o) - 36'h1)) == 36'h0);
  endproperty
  property p_gate; arst_n_i && clk_en_i && !global_irq_en_i |=> vec_req_o[35:2] == 34'h0; endproperty
  property p_spi_set; s_spi_on |=> vec_req_o[20]; endproperty
  property p_spi_clear; s_spi_on ##1 s_spi_off |=> !vec_req_o[20]; endproperty
  property p_normal_hunf; arst_n_i && clk_en_i && !timer_a_split_i |=> !vec_req_o[10]; endproperty
  property p_freeze; arst_n_i && !clk_en_i |=> $stable(vec_req_o) && $stable(vec_num_o); endproperty
  property p_eeprom;
    arst_n_i && clk_en_i && global_irq_en_i && src_i.eeprom_ready_irq.flag && src_i.eeprom_ready_irq.enable
      |=> vec_req_o[35];
  endproperty
  a_addr_twice: assert property (p_addr_twice) else $error("fetch address not twice vector");
  a_no_reset_vec: assert property (p_no_reset_vec) else $error("reset vector requested");
  a_nmi: assert property (p_nmi) else $error("nmi vector missing");
  a_lowest: assert property (p_lowest) else $error("vector number not lowest request");
  a_gate: assert property (p_gate) else $error("request while globally disabled");
  a_spi_set: assert property (p_spi_set) else $error("spi vector missing");
  a_spi_clear: assert property (p_spi_clear) else $error("spi vector held after clear");
  a_normal_hunf: assert property (p_normal_hunf) else $error("vector ten used in normal mode");
  a_freeze: assert property (p_freeze) else $error("outputs moved while clock disabled");
  a_eeprom: assert property (p_eeprom) else $error("eeprom vector missing");
endmodule

bind ivm_vector_map ivm_vector_map_checker chk_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
  .global_irq_en_i(global_irq_en_i), .timer_a_split_i(timer_a_split_i), .nmi_req_i(nmi_req_i), .src_i(src_i),
  .vec_req_o(vec_req_o), .vec_num_o(vec_num_o), .vec_addr_o(vec_addr_o));

// file: dv/tb.sv
// Random-stimulus bench for the vector map, compared each cycle with a reference model.
// Assumes a one-cycle registered answer and lowest-vector priority.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk_i = 1'b0, arst_n_i = 1'b0, clk_en_i = 1'b0, global_irq_en_i = 1'b0;
  logic                  timer_a_split_i = 1'b0, nmi_req_i = 1'b0, vlm_req_i = 1'b0, vec_any_o;
  ivm_pkg::ivm_sources_t src_i = '0;
  logic [35:0]           vec_req_o, exp_req = 36'h0;
  logic [5:0]            vec_num_o, exp_num;
  logic [6:0]            vec_addr_o, fetch_addr, exp_fetch = 7'h00;
  logic [95:0]           rnd;
  int                    errors = 0, n_tests = 0, seed = 6343, i;
  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  function automatic logic on(input ivm_pkg::ivm_src_t s);
    return s.flag & s.enable;
  endfunction
  function automatic logic [35:0] f_exp(input ivm_pkg::ivm_sources_t s, input logic g, sp, nmi, vlm);
    logic [35:0] r;
    int          b;
    r = 36'h0;
    r[1] = nmi; r[2] = vlm; r[3] = on(s.clock_fail_detect); r[4] = on(s.multivolt_io_irq);
    r[5] = on(s.rtc_overflow) | on(s.rtc_compare); r[6] = on(s.rtc_periodic_irq); r[7] = on(s.custom_logic_irq);
    r[8] = on(s.port_a_pin_irq); r[24] = on(s.port_d_pin_irq); r[29] = on(s.port_c_pin_irq);
    r[34] = on(s.port_f_pin_irq);
    r[9] = sp ? on(s.timer_a_low_underflow_irq) : on(s.timer_a_overflow_irq);
    r[10] = sp & on(s.timer_a_high_underflow_irq);
    for (b = 0; b < 3; b++)
    begin
      r[11+b] = sp ? on(s.timer_a_low_compare_irq[b]) : on(s.timer_a_compare_irq[b]);
    end
    r[14] = on(s.timer_b_capture[0]) | on(s.timer_b_overflow[0]);
    r[15] = on(s.timer_b_capture[1]) | on(s.timer_b_overflow[1]);
    r[30] = on(s.timer_b_capture[2]) | on(s.timer_b_overflow[2]);
    r[16] = on(s.timer_d_overflow_irq); r[17] = on(s.timer_d_trigger_irq);
    r[18] = on(s.twowire_client_irq); r[19] = on(s.twowire_host_irq); r[20] = on(s.serial_periph_irq);
    for (b = 0; b < 2; b++)
    begin
      r[21+10*b] = s.uart_flag[b].rx_done & s.uart_enable[b].rx_done;
      r[22+10*b] = s.uart_flag[b].tx_empty & s.uart_enable[b].tx_empty;
      r[23+10*b] = s.uart_flag[b].tx_done & s.uart_enable[b].tx_done;
    end
    r[25] = on(s.comparator_irq); r[26] = on(s.adc_result_ready_irq); r[27] = on(s.adc_window_irq);
    r[28] = on(s.zero_cross_irq); r[35] = on(s.eeprom_ready_irq);
    if (!g)
      r[35:2] = 34'h0;
    return r;
  endfunction
  // ---------------------------------------------------------------
  // Design, partner and comparison
  // ---------------------------------------------------------------
  ivm_vector_map dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .global_irq_en_i(global_irq_en_i), .timer_a_split_i(timer_a_split_i), .nmi_req_i(nmi_req_i),
    .vlm_req_i(vlm_req_i), .src_i(src_i), .vec_req_o(vec_req_o), .vec_any_o(vec_any_o),
    .vec_num_o(vec_num_o), .vec_addr_o(vec_addr_o));
  ivm_cpu_model cpu_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .vec_any_i(vec_any_o),
    .vec_addr_i(vec_addr_o), .fetch_addr_o(fetch_addr));
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      exp_req <= 36'h0;
    else if (clk_en_i)
      exp_req <= f_exp(src_i, global_irq_en_i, timer_a_split_i, nmi_req_i, vlm_req_i);
  // Core takes the word address of the lowest pending vector, free of the clock enable
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      exp_fetch <= 7'h00;
    else if (|exp_req)
      exp_fetch <= {exp_num, 1'b0};
  always @(negedge ref_clk_i)
  begin
    exp_num = 6'h00;
    for (int k = 35; k >= 0; k--)
      if (exp_req[k])
        exp_num = k[5:0];
    `CHK("vec_req low", exp_req[8:0], vec_req_o[8:0])
    `CHK("vec_req timer a", exp_req[13:9], vec_req_o[13:9])
    `CHK("vec_req upper", exp_req[35:14], vec_req_o[35:14])
    `CHK("vec_any", |exp_req, vec_any_o)
    `CHK("vec_num", exp_num, vec_num_o)
    `CHK("vec_addr", {exp_num, 1'b0}, vec_addr_o)
    `CHK("fetch_addr", exp_fetch, fetch_addr)
  end
  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    #16000;
    errors++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge ref_clk_i);
      rnd = {$random(seed), $random(seed), $random(seed)};
      // Sparse phases let high vectors win priority too
      if (i % 300 < 150)
        rnd = rnd & {$random(seed), $random(seed), $random(seed)};
      src_i           <= ivm_pkg::ivm_sources_t'(rnd[$bits(ivm_pkg::ivm_sources_t)-1:0]);
      clk_en_i        <= ($random(seed) & 7) != 0;
      global_irq_en_i <= ($random(seed) & 7) != 0;
      timer_a_split_i <= rnd[95];
      nmi_req_i       <= ($random(seed) & 15) == 0;
      vlm_req_i       <= ($random(seed) & 7) == 0;
      if (i == 1500)
        arst_n_i <= 1'b0;
      if (i == 1504)
        arst_n_i <= 1'b1;
    end
    end_of_test();
  end
endmodule
